// >>> src/spes_scaler.sv
// shunt power, energy and charge scaling datapath with its AHB-Lite register file
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

// What this block does
// - after each averaged shunt result, current equals shunt reading scaled by calibration register.
// - a zero calibration value gives a current result of zero.
// - current result least bit is weighted by the step implied by calibration.
// - power result is 24 bits, watts equal 3.2 times step times reading.
// - energy accumulator is 40-bit unsigned, joules are 16 times power weight.
// - charge accumulator is 40-bit signed two's complement, scaled by current step.
// - both accumulators wrap on overflow; energy continues from zero, charge from the other end of its signed range.
// - setting the clear bit in configuration clears energy and charge accumulators.
// - eight conversion times from 50 to 4120 microseconds are offered.
// - a selectable number of conversions is averaged into one output sample.
// - range bit clear selects 312.5 nV steps, set selects 78.125 nV steps.
module spes_scaler
   import spes_pkg::*;
#(
   parameter int unsigned CONV_CYCLES [8] = '{conv_cycles(0), conv_cycles(1), conv_cycles(2), conv_cycles(3),
                                              conv_cycles(4), conv_cycles(5), conv_cycles(6), conv_cycles(7)}
) (
   // clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // register bus
   input  wire spes_ahb_req_t ahb_req,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   // converter side
   input  wire logic          adc_valid,
   input  wire spes_sample_t  adc_data,
   output logic               adc_start,
   output logic               adc_range
);

   // ----------------------------------------------------------------
   // register file and bus slave
   // ----------------------------------------------------------------
   logic        range_reg,    range_next;
   logic [8:0]  adc_cfg_reg,  adc_cfg_next;
   logic [14:0] cal_reg,      cal_next;
   logic        rdy_reg,      rdy_next;
   logic        clr_reg,      clr_next;
   logic        wr_ph_reg,    wr_ph_next;
   logic [7:0]  wr_addr_reg,  wr_addr_next;
   logic [31:0] rdata_reg,    rdata_next;
   logic        addr_ok;

   logic signed [19:0] shunt_reg;
   logic        [19:0] bus_reg;
   logic signed [19:0] current_reg;
   logic        [23:0] power_reg;
   logic        [39:0] energy_reg;
   logic signed [39:0] charge_reg;
   logic               s3_reg;

   // register read mux, shared by the bus slave only
   function automatic logic [31:0] read_mux(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         ADDR_CONFIG:    v[CFG_RANGE_BIT] = range_reg;
         ADDR_ADC_CFG:   v[8:0] = adc_cfg_reg;
         ADDR_SHUNT_CAL: v[14:0] = cal_reg;
         ADDR_SHUNT:     v = {{12{shunt_reg[19]}}, shunt_reg};
         ADDR_BUS:       v[19:0] = bus_reg;
         ADDR_CURRENT:   v = {{12{current_reg[19]}}, current_reg};
         ADDR_POWER:     v[23:0] = power_reg;
         ADDR_ENERGY_LO: v = energy_reg[31:0];
         ADDR_ENERGY_HI: v[7:0] = energy_reg[39:32];
         ADDR_CHARGE_LO: v = charge_reg[31:0];
         ADDR_CHARGE_HI: v = {{24{charge_reg[39]}}, charge_reg[39:32]};
         ADDR_STATUS:    v[STAT_RDY_BIT] = rdy_reg;
         default:        v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   always_comb begin
      addr_ok      = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
      range_next   = range_reg;
      adc_cfg_next = adc_cfg_reg;
      cal_next     = cal_reg;
      clr_next     = 1'b0;
      wr_ph_next   = addr_ok && ahb_req.hwrite;
      wr_addr_next = addr_ok ? ahb_req.haddr[7:0] : wr_addr_reg;
      rdata_next   = (addr_ok && !ahb_req.hwrite) ? read_mux(ahb_req.haddr[7:0]) : 32'h0000_0000;
      rdy_next     = rdy_reg;
      if (addr_ok && !ahb_req.hwrite && ahb_req.haddr[7:0] == ADDR_STATUS) begin
         rdy_next = 1'b0;
      end
      // a new sample in the same cycle as the clearing read still sets the flag
      if (s3_reg) begin
         rdy_next = 1'b1;
      end
      if (wr_ph_reg) begin
         unique case (wr_addr_reg)
            ADDR_CONFIG: begin
               range_next = ahb_req.hwdata[CFG_RANGE_BIT];
               clr_next   = ahb_req.hwdata[CFG_CLR_BIT];
            end
            ADDR_ADC_CFG: begin
               adc_cfg_next = ahb_req.hwdata[8:0];
            end
            ADDR_SHUNT_CAL: begin
               cal_next     = ahb_req.hwdata[14:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         range_reg   <= RANGE_RST;
         adc_cfg_reg <= ADC_CFG_RST;
         cal_reg     <= CAL_RST;
         clr_reg     <= 1'b0;
         rdy_reg     <= 1'b0;
         wr_ph_reg   <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         range_reg   <= range_next;
         adc_cfg_reg <= adc_cfg_next;
         cal_reg     <= cal_next;
         clr_reg     <= clr_next;
         rdy_reg     <= rdy_next;
         wr_ph_reg   <= wr_ph_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg   <= rdata_next;
      end
   end

   // zero wait states: read data is prepared during the address phase
   logic        hready_reg;
   logic        hresp_reg;

   // the slave never stretches a transfer or reports an error, so both answer flops stay fixed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hready_reg <= 1'b1;
         hresp_reg  <= 1'b0;
      end else begin
         hready_reg <= 1'b1;
         hresp_reg  <= 1'b0;
      end
   end

   assign hreadyout = hready_reg;
   assign hresp     = hresp_reg;
   assign hrdata    = rdata_reg;
   assign adc_range = range_reg;

   // ----------------------------------------------------------------
   // conversion timer and averaging
   // ----------------------------------------------------------------
   logic [2:0]         ct_sel;
   logic [2:0]         avg_sel;
   logic               run;
   logic [19:0]        tmr_reg,   tmr_next;
   logic               start_reg, start_next;
   logic signed [29:0] sum_s_reg, sum_s_next;
   logic        [29:0] sum_b_reg, sum_b_next;
   logic [10:0]        n_reg,     n_next;
   logic               s1_reg,    s1_next;
   logic signed [19:0] shunt_next;
   logic        [19:0] bus_next;
   logic signed [29:0] sum_s_add;
   logic        [29:0] sum_b_add;
   logic [10:0]        n_add;
   logic [10:0]        avg_n;

   always_comb begin
      ct_sel     = adc_cfg_reg[ADC_CT_LSB +: 3];
      avg_sel    = adc_cfg_reg[ADC_AVG_LSB +: 3];
      run        = adc_cfg_reg[ADC_RUN_BIT];
      avg_n      = 11'h001 << AVG_LOG2[avg_sel];
      tmr_next   = tmr_reg;
      start_next = 1'b0;
      if (!run) begin
         tmr_next = 20'h00000;
      end else if (tmr_reg == 20'h00000) begin
         start_next = 1'b1;
         tmr_next   = 20'(CONV_CYCLES[ct_sel] - 1);
      end else begin
         tmr_next = tmr_reg - 20'h00001;
      end
      sum_s_add  = sum_s_reg + 30'(adc_data.shunt);
      sum_b_add  = sum_b_reg + {10'h000, adc_data.bus};
      n_add      = n_reg + 11'h001;
      sum_s_next = sum_s_reg;
      sum_b_next = sum_b_reg;
      n_next     = n_reg;
      s1_next    = 1'b0;
      shunt_next = shunt_reg;
      bus_next   = bus_reg;
      if (adc_valid) begin
         // >= so that lowering the count mid-way cannot strand the average
         if (n_add >= avg_n) begin
            s1_next    = 1'b1;
            shunt_next = 20'(sum_s_add >>> AVG_LOG2[avg_sel]);
            bus_next   = 20'(sum_b_add >> AVG_LOG2[avg_sel]);
            sum_s_next = 30'h0000_0000;
            sum_b_next = 30'h0000_0000;
            n_next     = 11'h000;
         end else begin
            sum_s_next = sum_s_add;
            sum_b_next = sum_b_add;
            n_next     = n_add;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr_reg   <= 20'h00000;
         start_reg <= 1'b0;
         sum_s_reg <= 30'h0000_0000;
         sum_b_reg <= 30'h0000_0000;
         n_reg     <= 11'h000;
         s1_reg    <= 1'b0;
         shunt_reg <= 20'h00000;
         bus_reg   <= 20'h00000;
      end else begin
         tmr_reg   <= tmr_next;
         start_reg <= start_next;
         sum_s_reg <= sum_s_next;
         sum_b_reg <= sum_b_next;
         n_reg     <= n_next;
         s1_reg    <= s1_next;
         shunt_reg <= shunt_next;
         bus_reg   <= bus_next;
      end
   end

   assign adc_start = start_reg;

   // ----------------------------------------------------------------
   // current, power and accumulators
   // ----------------------------------------------------------------
   logic signed [35:0] cur_prod;
   logic        [19:0] cur_mag;
   logic        [39:0] pow_prod;
   logic signed [19:0] current_next;
   logic        [23:0] power_next;
   logic        [39:0] energy_next;
   logic signed [39:0] charge_next;
   logic               s2_reg;

   always_comb begin
      // the calibration value weights the current step size
      cur_prod     = shunt_reg * $signed({1'b0, cal_reg});
      current_next = s1_reg ? 20'(cur_prod >>> CUR_SHIFT) : current_reg;
      cur_mag      = current_reg[19] ? 20'(-current_reg) : 20'(current_reg);
      pow_prod     = cur_mag * bus_reg;
      power_next   = s2_reg ? 24'(pow_prod >> POW_SHIFT) : power_reg;
      energy_next  = energy_reg;
      charge_next  = charge_reg;
      if (s2_reg) begin
         charge_next = charge_reg + 40'(current_reg);
      end
      if (s3_reg) begin
         energy_next = energy_reg + {16'h0000, power_reg};
      end
      // a clear request outranks an add in the same cycle
      if (clr_reg) begin
         energy_next = 40'h00_0000_0000;
         charge_next = 40'h00_0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         current_reg <= 20'h00000;
         power_reg   <= 24'h000000;
         energy_reg  <= 40'h00_0000_0000;
         charge_reg  <= 40'h00_0000_0000;
         s2_reg      <= 1'b0;
         s3_reg      <= 1'b0;
      end else begin
         current_reg <= current_next;
         power_reg   <= power_next;
         energy_reg  <= energy_next;
         charge_reg  <= charge_next;
         s2_reg      <= s1_reg;
         s3_reg      <= s2_reg;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [19:0] gap_reg;
   logic        gap_ok_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_reg    <= 20'h00000;
         gap_ok_reg <= 1'b0;
      end else begin
         gap_reg    <= start_reg ? 20'h00001 : gap_reg + 20'h00001;
         gap_ok_reg <= (wr_ph_reg && wr_addr_reg == ADDR_ADC_CFG) ? 1'b0 : (start_reg ? 1'b1 : gap_ok_reg);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence clr_write_s;
      wr_ph_reg && wr_addr_reg == ADDR_CONFIG && ahb_req.hwdata[CFG_CLR_BIT];
   endsequence

   sequence acc_zero_s;
      energy_reg == 40'h00_0000_0000 && charge_reg == 40'h00_0000_0000;
   endsequence

   sequence sample_chain_s;
      s1_reg ##1 s2_reg ##1 s3_reg;
   endsequence

   current_scale_a: assert property (s1_reg |=> current_reg == 20'($past(cur_prod) >>> CUR_SHIFT))
      else $error("current not scaled by calibration");
   cal_zero_a: assert property (s1_reg && cal_reg == 15'h0000 |=> current_reg == 20'h00000)
      else $error("current nonzero with zero calibration");
   power_calc_a: assert property (s2_reg |=> power_reg == 24'($past(pow_prod) >> POW_SHIFT))
      else $error("power result mismatch");
   energy_add_a: assert property (s3_reg && !clr_reg |=> energy_reg == $past(energy_reg) + {16'h0000, $past(power_reg)})
      else $error("energy did not accumulate power");
   charge_add_a: assert property (s2_reg && !clr_reg |=> charge_reg == $past(charge_reg) + 40'($past(current_reg)))
      else $error("charge did not accumulate current");
   acc_clear_a: assert property (clr_write_s |-> ##2 acc_zero_s)
      else $error("accumulators not cleared");
   conv_period_a: assert property (start_reg && gap_ok_reg && run |-> gap_reg == 20'(CONV_CYCLES[ct_sel]))
      else $error("conversion start spacing wrong");
   avg_done_a: assert property (adc_valid && n_add >= avg_n |=> s1_reg ##0 n_reg == 11'h000)
      else $error("average not completed at count");
   range_out_a: assert property (wr_ph_reg && wr_addr_reg == ADDR_CONFIG |=> adc_range == $past(ahb_req.hwdata[CFG_RANGE_BIT]))
      else $error("range select not applied");
   chain_a: assert property (s1_reg |-> sample_chain_s ##1 rdy_reg)
      else $error("sample did not reach accumulators");

endmodule

// >>> common/spes_pkg.sv
// constants, register map and carriers of the shunt power and energy scaler
package spes_pkg;

   // ----------------------------------------------------------------
   // clock and conversion timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int CONV_TIME_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
   localparam int AVG_LOG2 [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

   // cycles per conversion, rounded to whole cycles of the 200 MHz clock
   function automatic int conv_cycles(input int idx);
      return CONV_TIME_US[idx] * CLK_MHZ;
   endfunction

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG    = 8'h00;
   localparam logic [7:0] ADDR_ADC_CFG   = 8'h04;
   localparam logic [7:0] ADDR_SHUNT_CAL = 8'h08;
   localparam logic [7:0] ADDR_SHUNT     = 8'h0C;
   localparam logic [7:0] ADDR_BUS       = 8'h10;
   localparam logic [7:0] ADDR_CURRENT   = 8'h14;
   localparam logic [7:0] ADDR_POWER     = 8'h18;
   localparam logic [7:0] ADDR_ENERGY_LO = 8'h1C;
   localparam logic [7:0] ADDR_ENERGY_HI = 8'h20;
   localparam logic [7:0] ADDR_CHARGE_LO = 8'h24;
   localparam logic [7:0] ADDR_CHARGE_HI = 8'h28;
   localparam logic [7:0] ADDR_STATUS    = 8'h2C;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CFG_CLR_BIT   = 0;
   localparam int CFG_RANGE_BIT = 4;
   localparam int ADC_CT_LSB    = 0;
   localparam int ADC_AVG_LSB   = 4;
   localparam int ADC_RUN_BIT   = 8;
   localparam int STAT_RDY_BIT  = 0;
   localparam logic        RANGE_RST   = 1'b0;
   localparam logic [8:0]  ADC_CFG_RST = 9'h000;
   localparam logic [14:0] CAL_RST     = 15'h0000;

   // ----------------------------------------------------------------
   // datapath scaling
   // ----------------------------------------------------------------
   localparam int CUR_SHIFT = 12;
   localparam int POW_SHIFT = 16;

   // one raw conversion from the converter, before the scaler averages it
   typedef struct packed {
      logic signed [19:0] shunt;
      logic        [19:0] bus;
   } spes_sample_t;

   // AHB-Lite request from the master
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } spes_ahb_req_t;

endpackage

// >>> verification/spes_adc_model.sv
// converter stand-in that answers each start request with one sample
`timescale 1ns/1ps
module spes_adc_model
   import spes_pkg::*;
(
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // requests
   input  wire logic         adc_start,
   input  wire logic         kick,
   input  wire spes_sample_t value,
   // sample out
   output logic              adc_valid,
   output spes_sample_t      adc_data
);
   int unsigned  cnt;
   logic [39:0]  junk;
   spes_sample_t held;

   // ----------------------------------------------------------------
   // one conversion per request, a fixed few cycles later
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         adc_valid <= 1'b0;
         junk <= 40'hA5A5A5A5A5;
         held <= '0;
      end else begin
         junk <= {junk[38:0], ~junk[39]};
         adc_valid <= (cnt == 1);
         held <= value;
         if (adc_start || kick) begin
            cnt <= 3;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end

   // between samples the lines churn, so a stale value never passes for a fresh one
   assign adc_data = adc_valid ? held : spes_sample_t'(junk);
endmodule

// >>> verification/spes_scaler_test.sv
// self-checking bench of the scaler: register traffic, samples and conversion timing
`timescale 1ns/1ps
module spes_scaler_test
   import spes_pkg::*;
;
   localparam int unsigned CT [8] = '{20, 30, 40, 50, 60, 70, 80, 90};
   localparam longint      M40    = 64'hFF_FFFF_FFFF;

   logic          hclk;
   logic          hresetn;
   spes_ahb_req_t m;
   spes_ahb_req_t bus;
   logic          hreadyout;
   logic          hresp;
   logic [31:0]   hrdata;
   logic          adc_valid;
   spes_sample_t  adc_data;
   logic          adc_start;
   logic          adc_range;
   logic          kick;
   spes_sample_t  val;
   int            n_errors;
   int            n_tests;
   longint        e_acc;
   longint        q_acc;
   logic [31:0]   r;
   int            n;
   logic [7:0]    ra [7] = '{ADDR_CONFIG, ADDR_ADC_CFG, ADDR_SHUNT_CAL, ADDR_CURRENT, ADDR_POWER,
                             ADDR_ENERGY_HI, 8'h30};

   assign bus = '{hsel: m.hsel, haddr: m.haddr, htrans: m.htrans, hwrite: m.hwrite, hsize: m.hsize,
                  hready: hreadyout, hwdata: m.hwdata};

   spes_scaler #(.CONV_CYCLES(CT)) dut (
      .hclk(hclk), .hresetn(hresetn), .ahb_req(bus), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .adc_valid(adc_valid), .adc_data(adc_data), .adc_start(adc_start),
      .adc_range(adc_range));

   spes_adc_model adc (
      .hclk(hclk), .hresetn(hresetn), .adc_start(adc_start), .kick(kick), .value(val),
      .adc_valid(adc_valid), .adc_data(adc_data));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // ----------------------------------------------------------------
   // report and bus tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic give_up(input string nm);
      $display("[FAIL] %s: expected an answer, saw none", nm);
      n_errors++;
      summarize();
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s: expected %h, seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   // wait states are honoured by polling, never assumed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int i;
      @(posedge hclk);
      m.hsel <= 1'b1;
      m.htrans <= 2'b10;
      m.haddr <= {24'h0, a};
      m.hwrite <= w;
      m.hsize <= 3'b010;
      i = 0;
      // hready and read data are taken as they stand at each rising edge
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      m.hsel <= 1'b0;
      m.htrans <= 2'b00;
      m.hwdata <= wd;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 100);
      rd = hrdata;
      if (i >= 100) give_up("bus ready");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      chk(nm, e, x);
   endtask

   task automatic pulse();
      @(posedge hclk);
      kick <= 1'b1;
      @(posedge hclk);
      kick <= 1'b0;
   endtask

   // one sample with run off, then every result against the expected arithmetic
   task automatic smp(input logic signed [19:0] s, input logic [19:0] b, input longint cal);
      longint c;
      longint p;
      logic [31:0] st;
      int i;
      val <= '{shunt: s, bus: b};
      pulse();
      i = 0;
      do begin
         xfer(1'b0, ADDR_STATUS, 32'h0, st);
         i++;
      end while (st[0] !== 1'b1 && i < 20);
      if (i >= 20) give_up("sample ready");
      c = (s * cal) >>> 12;
      c = ((c & 64'hFFFFF) ^ 64'h80000) - 64'h80000;
      p = (((c < 0) ? -c : c) * b >> 16) & 64'hFFFFFF;
      e_acc = (e_acc + p) & M40;
      q_acc = (q_acc + c) & M40;
      rdc(ADDR_CURRENT, c[31:0], "current");
      rdc(ADDR_POWER, p[31:0], "power");
      rdc(ADDR_ENERGY_LO, e_acc[31:0], "energy lo");
      rdc(ADDR_ENERGY_HI, {24'h0, e_acc[39:32]}, "energy hi");
      rdc(ADDR_CHARGE_LO, q_acc[31:0], "charge lo");
      rdc(ADDR_CHARGE_HI, {{24{q_acc[39]}}, q_acc[39:32]}, "charge hi");
   endtask

   task automatic wait_start(output int c);
      c = 0;
      do begin
         @(negedge hclk);
         c++;
      end while (adc_start !== 1'b1 && c < 500);
      if (c >= 500) give_up("start pulse");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      m = '0;
      kick = 1'b0;
      val = '0;
      hresetn = 1'b0;
      n_errors = 0;
      n_tests = 0;
      e_acc = 0;
      q_acc = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk("idle outputs", 32'h0, {29'h0, adc_start, adc_range, hresp});
      wr(8'h30, 32'hFFFFFFFF);
      foreach (ra[k]) rdc(ra[k], 32'h0, "reset value");
      smp(20'sh01000, 20'h80000, 0);
      wr(ADDR_SHUNT_CAL, 32'h4000);
      smp(20'sh01000, 20'h80000, 64'h4000);
      smp(-20'sh01000, 20'h80000, 64'h4000);
      smp(-20'sh00C00, 20'hFFFFF, 64'h4000);
      wr(ADDR_CONFIG, 32'h10);
      @(negedge hclk);
      chk("range pin", 32'h1, {31'h0, adc_range});
      wr(ADDR_SHUNT_CAL, 32'h1000 * 4);
      smp(20'sh00200, 20'h40000, 64'h4000);
      wr(ADDR_CONFIG, 32'h11);
      e_acc = 0;
      q_acc = 0;
      rdc(ADDR_CONFIG, 32'h10, "config");
      rdc(ADDR_ENERGY_LO, 32'h0, "energy cleared");
      rdc(ADDR_CHARGE_HI, 32'h0, "charge cleared");
      smp(-20'sh00300, 20'h20000, 64'h4000);
      wr(ADDR_ADC_CFG, 32'h10);
      xfer(1'b0, ADDR_STATUS, 32'h0, r);
      for (int k = 0; k < 4; k++) begin
         val <= '{shunt: 20'(4 * (k + 1)), bus: 20'h100};
         pulse();
         repeat (8) @(posedge hclk);
         rdc(ADDR_STATUS, (k == 3) ? 32'h1 : 32'h0, "average ready");
      end
      rdc(ADDR_SHUNT, 32'd10, "averaged shunt");
      rdc(ADDR_BUS, 32'h100, "averaged bus");
      wr(ADDR_ADC_CFG, 32'h20);
      for (int k = 0; k < 16; k++) begin
         val <= '{shunt: -20'(k), bus: 20'(k)};
         pulse();
         repeat (4) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      // the signed average rounds toward minus infinity
      rdc(ADDR_SHUNT, 32'hFFFF_FFF8, "sixteen shunt");
      rdc(ADDR_BUS, 32'h0000_0007, "sixteen bus");
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_ADC_CFG, 32'h100 | k);
         wait_start(n);
         wait_start(n);
         chk("start period", CT[k], 32'(n));
         wr(ADDR_ADC_CFG, 32'h0);
      end
      summarize();
   end
endmodule
